// ---- vir_map.svh ----
// constants of the vectored interrupt router: sizes, bit slots, reset values
// assumes inclusion by vir_pkg and the design modules by bare name
`ifndef VIR_MAP_SVH
`define VIR_MAP_SVH

// ****************************************************************
// sizes
// ****************************************************************
`define VIR_NSRC 3
`define VIR_NMOD 8
`define VIR_NDST 4
`define VIR_NEXT 2

// ****************************************************************
// source bit slots and destination replication slots
// ****************************************************************
`define VIR_SRC_AGG 0
`define VIR_SRC_EXT_A 1
`define VIR_SRC_EXT_B 2
`define VIR_DST_CPU_A 0
`define VIR_DST_CPU_B 1
`define VIR_DST_EXT_A 2
`define VIR_DST_EXT_B 3

// ****************************************************************
// reset values
// ****************************************************************
`define VIR_RST_BIT 1'h0
`define VIR_RST_OE_N 1'h1

`endif

// ---- vir_pkg.sv ----
// types of the vectored interrupt router
// assumes vir_map.svh is on the include path
`include "vir_map.svh"

package vir_pkg;

    // detection modes of one source
    typedef enum logic [1:0] {
        VIR_LEVEL = 2'h0,
        VIR_ANY_EDGE = 2'h1,
        VIR_FALL_EDGE = 2'h2,
        VIR_RISE_EDGE = 2'h3
    } vir_mode_e;

    // per-source configuration of the top-level source stage
    typedef struct packed {
        logic [`VIR_NSRC-1:0][1:0] detect_mode;
        logic [`VIR_NSRC-1:0] latch_bypass;
        logic [`VIR_NSRC-1:0] enable_mask;
    } vir_src_cfg_s;

    // per-module configuration of the port-module stage
    typedef struct packed {
        logic [`VIR_NMOD-1:0][1:0] detect_mode;
        logic [`VIR_NMOD-1:0] latch_bypass;
        logic [`VIR_NMOD-1:0] enable_mask;
    } vir_mod_cfg_s;

endpackage : vir_pkg

// ---- vir_src_cell.sv ----
// one source stage: edge/level detection, latched events, bypass, enable
// assumes active-high levels on mclk, already synchronised by the caller
`timescale 1ns/1ps
`include "vir_map.svh"

module vir_src_cell
    import vir_pkg::*;
#(
    parameter int N = `VIR_NSRC
) (
    // clock and reset
    input wire logic mclk,
    input wire logic arst_n,
    // sources and configuration
    input wire logic [N-1:0] level,
    input wire logic [N-1:0][1:0] detect_mode,
    input wire logic [N-1:0] latch_bypass,
    input wire logic [N-1:0] enable_mask,
    input wire logic [N-1:0] clear_pulse,
    // state
    output logic [N-1:0] latched,
    output logic [N-1:0] presented
);

    logic [N-1:0] prev_q;
    logic [N-1:0] latched_q;
    logic [N-1:0] hit;

    // previous sample for edge detection; 0 at reset, so a source already
    // high when reset lifts counts as a rising edge
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            prev_q <= '0;
        end else begin
            prev_q <= level;
        end
    end

    // qualifying events per mode
    always_comb begin
        hit = '0;
        for (int i = 0; i < N; i++) begin
            unique case (vir_mode_e'(detect_mode[i]))
                VIR_LEVEL: hit[i] = level[i];
                VIR_ANY_EDGE: hit[i] = level[i] ^ prev_q[i];
                VIR_FALL_EDGE: hit[i] = prev_q[i] & ~level[i];
                VIR_RISE_EDGE: hit[i] = ~prev_q[i] & level[i];
            endcase
        end
    end

    // write-one-to-clear, with a same-cycle event winning over the clear
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            latched_q <= '0;
        end else begin
            latched_q <= (latched_q & ~clear_pulse) | hit;
        end
    end

    assign latched = latched_q;
    // bypass takes the raw level and ignores latch and mode
    assign presented = ((latch_bypass & level) | (~latch_bypass & latched_q))
                       & enable_mask;

    for (genvar g = 0; g < N; g++) begin : g_chk
        level_set_a: assert property (@(posedge mclk) disable iff (!arst_n)
            (detect_mode[g] == 2'h0 && level[g]) |=> latched[g])
            else $error("level source did not latch");
        event_only_a: assert property (@(posedge mclk) disable iff (!arst_n)
            $rose(latched[g]) |-> $past(detect_mode[g] == 2'h0 ? level[g] :
                detect_mode[g] == 2'h1 ? level[g] != prev_q[g] :
                detect_mode[g] == 2'h2 ? prev_q[g] && !level[g] :
                !prev_q[g] && level[g]))
            else $error("latched bit set without its event");
        rise_set_a: assert property (@(posedge mclk) disable iff (!arst_n)
            (detect_mode[g] == 2'h3 && !prev_q[g] && level[g]) |=> latched[g])
            else $error("rising edge not latched");
        fall_set_a: assert property (@(posedge mclk) disable iff (!arst_n)
            (detect_mode[g] == 2'h2 && prev_q[g] && !level[g]) |=> latched[g])
            else $error("falling edge not latched");
        clear_hold_a: assert property (@(posedge mclk) disable iff (!arst_n)
            latched[g] |=> latched[g] == !$past(clear_pulse[g]) || $past(hit[g]))
            else $error("latched bit clear or hold wrong");
        set_wins_a: assert property (@(posedge mclk) disable iff (!arst_n)
            (clear_pulse[g] && hit[g]) |=> latched[g])
            else $error("clear beat a same-cycle event");
    end

endmodule : vir_src_cell

// ---- vir_top.sv ----
// vectored interrupt router: port-module hierarchy, top source stage,
// four destinations, two external inputs and two external outputs
// assumes one clock mclk; pins outside mclk come in on ext_in_pin_*;
// port-module interrupts and all configuration are on mclk already
//
// Summary of operation
// - four destinations: two processor lines, two external output pins
// - all internal signals active high; polarity fixed at entry and exit
// - raw view always shows the unlatched source level, one cycle late
// - level mode sets the latched bit every cycle the source is active
// - any-edge mode sets the latched bit when the level changes
// - falling-edge mode sets it when the source goes inactive
// - rising-edge mode sets it when the source goes active
// - writing one clears a latched bit, writing zero leaves it
// - a same-cycle event beats the clear and sets the bit again
// - a source is presented when latched and enabled
// - source pending view is presented state and enable
// - bypass uses the raw level instead of latch and mode
// - destination asserts when any presented source is in its mask
// - destination pending view shows presented sources in its mask
// - each port-module interrupt passes its own polarity bit first
// - port-module stage works exactly like the top source stage
// - enabled pending module interrupts are ORed into one source
// - aggregate on bit 0, external inputs on bits 1 and 2
// - two inputs and two outputs, independent, each own polarity
// - drive style 0 drives the output pin at both levels
// - drive style 1 with polarity 0 emulates open collector
// - a mapped output takes the shared pin from the input
`timescale 1ns/1ps
`include "vir_map.svh"

module vir_top
    import vir_pkg::*;
(
    // clock and reset
    input wire logic mclk,
    input wire logic arst_n,
    // port-module interrupts and their configuration
    input wire logic [`VIR_NMOD-1:0] module_irq,
    input wire logic [`VIR_NMOD-1:0] module_polarity,
    input wire vir_mod_cfg_s module_cfg,
    input wire logic [`VIR_NMOD-1:0] module_clear,
    // top source configuration
    input wire vir_src_cfg_s source_cfg,
    input wire logic [`VIR_NSRC-1:0] source_clear,
    // destination masks, one per replication slot
    input wire logic [`VIR_NDST-1:0][`VIR_NSRC-1:0] dest_route_mask,
    // external pin configuration, index 0 is line a, 1 is line b
    input wire logic [`VIR_NEXT-1:0] ext_input_polarity,
    input wire logic [`VIR_NEXT-1:0] ext_output_polarity,
    input wire logic [`VIR_NEXT-1:0] ext_output_drive_style,
    input wire logic [`VIR_NEXT-1:0] ext_out_pin_sel,
    // external shared pins
    input wire logic ext_in_pin_a,
    input wire logic ext_in_pin_b,
    output logic ext_out_pin_a,
    output logic ext_out_pin_a_oe_n,
    output logic ext_out_pin_b,
    output logic ext_out_pin_b_oe_n,
    // processor interrupt lines
    output logic processor_irq_line_a,
    output logic processor_irq_line_b,
    // top source status
    output logic [`VIR_NSRC-1:0] source_raw_level,
    output logic [`VIR_NSRC-1:0] source_latched_event,
    output logic [`VIR_NSRC-1:0] source_pending_view,
    // destination status
    output logic [`VIR_NDST-1:0][`VIR_NSRC-1:0] dest_pending_view,
    // port-module status
    output logic [`VIR_NMOD-1:0] module_raw_level,
    output logic [`VIR_NMOD-1:0] module_latched_event,
    output logic [`VIR_NMOD-1:0] module_pending_view
);

    // ****************************************************************
    // external input synchronisers
    // ****************************************************************

    logic [`VIR_NEXT-1:0] sync1_q;
    logic [`VIR_NEXT-1:0] sync2_q;
    logic [1:0] fill_q;

    // the stages leave reset at 0, which an active-low pin would read as
    // asserted; inputs stay idle until both stages carry real pin data
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            fill_q <= 2'h0;
        end else begin
            fill_q <= {fill_q[0], 1'h1};
        end
    end

    // two stages before any logic; the first is read only by the second
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            sync1_q <= '0;
            sync2_q <= '0;
        end else begin
            sync1_q <= {ext_in_pin_b, ext_in_pin_a};
            sync2_q <= sync1_q;
        end
    end

    // ****************************************************************
    // port-module hierarchy
    // ****************************************************************

    logic [`VIR_NMOD-1:0] mod_level;
    logic [`VIR_NMOD-1:0] mod_latched;
    logic [`VIR_NMOD-1:0] mod_presented;
    logic mod_aggregate;

    // polarity 1 keeps the line, 0 inverts an active-low module line
    assign mod_level = module_irq ^ ~module_polarity;

    // same cell as the top stage, so both behave identically
    vir_src_cell #(
        .N(`VIR_NMOD)
    ) u_mod_stage (
        .mclk(mclk),
        .arst_n(arst_n),
        .level(mod_level),
        .detect_mode(module_cfg.detect_mode),
        .latch_bypass(module_cfg.latch_bypass),
        .enable_mask(module_cfg.enable_mask),
        .clear_pulse(module_clear),
        .latched(mod_latched),
        .presented(mod_presented)
    );

    // every enabled pending module folds into one source
    assign mod_aggregate = |mod_presented;

    // ****************************************************************
    // top source stage
    // ****************************************************************

    logic [`VIR_NEXT-1:0] ext_level;
    logic [`VIR_NSRC-1:0] src_level;
    logic [`VIR_NSRC-1:0] src_latched;
    logic [`VIR_NSRC-1:0] src_presented;

    // polarity after the synchroniser; a pin taken by its output reads idle
    assign ext_level = (sync2_q ^ ~ext_input_polarity) & ~ext_out_pin_sel
                       & {`VIR_NEXT{fill_q[1]}};

    // fixed source slots
    always_comb begin
        src_level = '0;
        src_level[`VIR_SRC_AGG] = mod_aggregate;
        src_level[`VIR_SRC_EXT_A] = ext_level[0];
        src_level[`VIR_SRC_EXT_B] = ext_level[1];
    end

    vir_src_cell #(
        .N(`VIR_NSRC)
    ) u_src_stage (
        .mclk(mclk),
        .arst_n(arst_n),
        .level(src_level),
        .detect_mode(source_cfg.detect_mode),
        .latch_bypass(source_cfg.latch_bypass),
        .enable_mask(source_cfg.enable_mask),
        .clear_pulse(source_clear),
        .latched(src_latched),
        .presented(src_presented)
    );

    // ****************************************************************
    // destinations
    // ****************************************************************

    logic [`VIR_NDST-1:0][`VIR_NSRC-1:0] dst_view;
    logic [`VIR_NDST-1:0] dst_active;

    // each slot masks the presented sources on its own
    always_comb begin
        for (int d = 0; d < `VIR_NDST; d++) begin
            dst_view[d] = src_presented & dest_route_mask[d];
            dst_active[d] = |dst_view[d];
        end
    end

    // ****************************************************************
    // status registers
    // ****************************************************************

    logic [`VIR_NSRC-1:0] src_raw_q;
    logic [`VIR_NSRC-1:0] src_latched_q;
    logic [`VIR_NSRC-1:0] src_view_q;
    logic [`VIR_NDST-1:0][`VIR_NSRC-1:0] dst_view_q;
    logic [`VIR_NMOD-1:0] mod_raw_q;
    logic [`VIR_NMOD-1:0] mod_latched_q;
    logic [`VIR_NMOD-1:0] mod_view_q;

    // views are one cycle behind the logic, all from the same edge,
    // so they agree with each other and with the interrupt lines
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            src_raw_q <= '0;
            src_latched_q <= '0;
            src_view_q <= '0;
            dst_view_q <= '0;
            mod_raw_q <= '0;
            mod_latched_q <= '0;
            mod_view_q <= '0;
        end else begin
            src_raw_q <= src_level;
            src_latched_q <= src_latched;
            src_view_q <= src_presented;
            dst_view_q <= dst_view;
            mod_raw_q <= mod_level;
            mod_latched_q <= mod_latched;
            mod_view_q <= mod_presented;
        end
    end

    assign source_raw_level = src_raw_q;
    assign source_latched_event = src_latched_q;
    assign source_pending_view = src_view_q;
    assign dest_pending_view = dst_view_q;
    assign module_raw_level = mod_raw_q;
    assign module_latched_event = mod_latched_q;
    assign module_pending_view = mod_view_q;

    // ****************************************************************
    // processor lines
    // ****************************************************************

    logic cpu_a_q;
    logic cpu_b_q;

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            cpu_a_q <= `VIR_RST_BIT;
            cpu_b_q <= `VIR_RST_BIT;
        end else begin
            cpu_a_q <= dst_active[`VIR_DST_CPU_A];
            cpu_b_q <= dst_active[`VIR_DST_CPU_B];
        end
    end

    assign processor_irq_line_a = cpu_a_q;
    assign processor_irq_line_b = cpu_b_q;

    // ****************************************************************
    // external output pins
    // ****************************************************************

    logic [`VIR_NEXT-1:0] pin_q;
    logic [`VIR_NEXT-1:0] oe_n_q;
    logic [`VIR_NEXT-1:0] ext_dst;

    assign ext_dst = {dst_active[`VIR_DST_EXT_B], dst_active[`VIR_DST_EXT_A]};

    // drive style 1 is always open collector: polarity 1 with it is not a
    // useful setting, so the pin is still only ever pulled low
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            pin_q <= '0;
            oe_n_q <= {`VIR_NEXT{`VIR_RST_OE_N}};
        end else begin
            for (int e = 0; e < `VIR_NEXT; e++) begin
                if (!ext_out_pin_sel[e]) begin
                    pin_q[e] <= 1'h0; // pin left to the input
                    oe_n_q[e] <= 1'h1;
                end else if (ext_output_drive_style[e]) begin
                    pin_q[e] <= 1'h0;
                    oe_n_q[e] <= ~ext_dst[e];
                end else begin
                    pin_q[e] <= ext_dst[e] ~^ ext_output_polarity[e];
                    oe_n_q[e] <= 1'h0;
                end
            end
        end
    end

    assign ext_out_pin_a = pin_q[0];
    assign ext_out_pin_a_oe_n = oe_n_q[0];
    assign ext_out_pin_b = pin_q[1];
    assign ext_out_pin_b_oe_n = oe_n_q[1];

    // ****************************************************************
    // checks
    // ****************************************************************

    sync_delay_a: assert property (@(posedge mclk) disable iff (!arst_n)
        (!ext_out_pin_sel[0] && ext_input_polarity[0]) [*4]
        |-> source_raw_level[1] == $past(ext_in_pin_a, 3))
        else $error("external input a not seen after two stages");

    input_taken_a: assert property (@(posedge mclk) disable iff (!arst_n)
        $past(ext_out_pin_sel[0]) |-> !source_raw_level[1])
        else $error("mapped pin still feeds the input source");

    aggregate_or_a: assert property (@(posedge mclk) disable iff (!arst_n)
        source_raw_level[0] == (|module_pending_view))
        else $error("aggregate source disagrees with module views");

    module_pol_a: assert property (@(posedge mclk) disable iff (!arst_n)
        module_raw_level == $past(module_irq ^ ~module_polarity))
        else $error("module polarity not applied");

    dest_view_a: assert property (@(posedge mclk) disable iff (!arst_n)
        dest_pending_view[2] == (source_pending_view & $past(dest_route_mask[2])))
        else $error("destination view not masked pending view");

    cpu_line_a: assert property (@(posedge mclk) disable iff (!arst_n)
        processor_irq_line_a == (|dest_pending_view[0])
        && processor_irq_line_b == (|dest_pending_view[1]))
        else $error("processor line disagrees with its view");

    push_pull_a: assert property (@(posedge mclk) disable iff (!arst_n)
        $past(ext_out_pin_sel[0] && !ext_output_drive_style[0])
        |-> !ext_out_pin_a_oe_n && ext_out_pin_a ==
            ((|dest_pending_view[2]) == $past(ext_output_polarity[0])))
        else $error("push-pull output wrong");

    open_coll_a: assert property (@(posedge mclk) disable iff (!arst_n)
        $past(ext_out_pin_sel[0] && ext_output_drive_style[0])
        |-> !ext_out_pin_a && ext_out_pin_a_oe_n == !(|dest_pending_view[2]))
        else $error("open-collector output wrong");

    pending_en_a: assert property (@(posedge mclk) disable iff (!arst_n)
        (source_pending_view & ~$past(source_cfg.enable_mask)) == '0)
        else $error("disabled source shown pending");

endmodule : vir_top

// ---- vir_far_side.sv ----
// board side model: shared interrupt wires with pull-up, input pins
// assumes oe_n low means driving and a pin selected as output is shared
`timescale 1ns/1ps

module vir_far_side (
    // pins from the router
    input wire logic ext_out_pin_a,
    input wire logic ext_out_pin_a_oe_n,
    input wire logic ext_out_pin_b,
    input wire logic ext_out_pin_b_oe_n,
    input wire logic [1:0] pin_sel,
    // levels that the board wants on the input pins
    input wire logic req_a,
    input wire logic req_b,
    // resolved wires
    output logic wire_a,
    output logic wire_b,
    output logic ext_in_pin_a,
    output logic ext_in_pin_b
);
    // ****************************************************************
    // wire resolution
    // ****************************************************************
    // released wire floats up through the resistor, never holds old value
    assign wire_a = ext_out_pin_a_oe_n ? 1'b1 : ext_out_pin_a;
    assign wire_b = ext_out_pin_b_oe_n ? 1'b1 : ext_out_pin_b;
    // a pin taken by the output shows the wire, not the board level
    assign ext_in_pin_a = pin_sel[0] ? wire_a : req_a;
    assign ext_in_pin_b = pin_sel[1] ? wire_b : req_b;
endmodule : vir_far_side

// ---- vectored_interrupt_router_tb.sv ----
// self-checking bench of vir_top with the board model beside it
// assumes vir_pkg compiled first; settle times exceed the longest path
`timescale 1ns/1ps

module vectored_interrupt_router_tb;
    import vir_pkg::*;
    typedef struct packed {logic [3:0] k; logic [15:0] v;} vir_note_s;
    logic mclk = 1'b0;
    logic arst_n = 1'b0;
    logic [7:0] m_irq = 8'h00, m_pol = 8'hFF, m_clr = 8'h00;
    vir_mod_cfg_s m_cfg = '0;
    vir_src_cfg_s s_cfg = '0;
    logic [2:0] s_clr = 3'h0;
    logic [3:0][2:0] d_mask = '0;
    logic [1:0] in_pol = 2'h3, out_pol = 2'h3, drv = 2'h0, sel = 2'h0;
    logic req_a = 1'b0, req_b = 1'b0;
    logic pin_a, pin_b, out_a, oe_a, out_b, oe_b, cpu_a, cpu_b, wire_a, wire_b;
    logic [2:0] raw, lat, pend;
    logic [3:0][2:0] dview;
    logic [7:0] mraw, mlat, mpend, r_irq, r_pol, e_lat, r_en;
    vir_note_s q[$];
    int bad_count = 0, cmp_count = 0, seed = 32'h0b889c17;
    logic [3:0] on_t[3] = '{4'hD, 4'h8, 4'h8}, off_t[3] = '{4'h8, 4'hD, 4'hB};

    vir_top i_vir_top (.mclk(mclk), .arst_n(arst_n), .module_irq(m_irq),
        .module_polarity(m_pol), .module_cfg(m_cfg), .module_clear(m_clr),
        .source_cfg(s_cfg), .source_clear(s_clr), .dest_route_mask(d_mask),
        .ext_input_polarity(in_pol), .ext_output_polarity(out_pol),
        .ext_output_drive_style(drv), .ext_out_pin_sel(sel),
        .ext_in_pin_a(pin_a), .ext_in_pin_b(pin_b), .ext_out_pin_a(out_a),
        .ext_out_pin_a_oe_n(oe_a), .ext_out_pin_b(out_b), .ext_out_pin_b_oe_n(oe_b),
        .processor_irq_line_a(cpu_a), .processor_irq_line_b(cpu_b),
        .source_raw_level(raw), .source_latched_event(lat), .source_pending_view(pend),
        .dest_pending_view(dview), .module_raw_level(mraw),
        .module_latched_event(mlat), .module_pending_view(mpend));

    vir_far_side i_vir_far_side (.ext_out_pin_a(out_a), .ext_out_pin_a_oe_n(oe_a),
        .ext_out_pin_b(out_b), .ext_out_pin_b_oe_n(oe_b), .pin_sel(sel),
        .req_a(req_a), .req_b(req_b), .wire_a(wire_a), .wire_b(wire_b),
        .ext_in_pin_a(pin_a), .ext_in_pin_b(pin_b));

    // ****************************************************************
    // clock, checking helpers and watchdog
    // ****************************************************************
    always #4 mclk = ~mclk;

    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
    endtask : tick

    task automatic note(input logic [3:0] k, input logic [15:0] v);
        q.push_back({k, v});
    endtask : note

    // one clear pulse on every latched bit, a single cycle wide
    task automatic clr();
        s_clr <= 3'h7;
        m_clr <= 8'hFF;
        tick(1);
        s_clr <= 3'h0;
        m_clr <= 8'h00;
        tick(1);
    endtask : clr

    function automatic logic [15:0] obs(input logic [3:0] k);
        case (k)
            4'h0: obs = {13'h0, raw};
            4'h1: obs = {13'h0, lat};
            4'h2: obs = {13'h0, pend};
            4'h3: obs = {14'h0, cpu_b, cpu_a};
            4'h4: obs = {4'h0, dview};
            4'h5: obs = {8'h0, mraw};
            4'h6: obs = {8'h0, mlat};
            4'h7: obs = {8'h0, mpend};
            4'h9: obs = {13'h0, out_b, oe_b, wire_b};
            default: obs = {12'h0, oe_b, out_a, oe_a, wire_a};
        endcase
    endfunction : obs

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    // notes are taken off half a cycle later, once outputs have settled
    always @(negedge mclk) begin
        while (q.size() > 0) begin
            vir_note_s n;
            n = q.pop_front();
            check(obs(n.k), n.v);
        end
    end

    task automatic stop_test();
        $display("compares %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : stop_test

    initial begin
        #40000;
        bad_count++;
        stop_test();
    end

    // ****************************************************************
    // main sequence
    // ****************************************************************
    initial begin
        tick(8);
        arst_n <= 1'b1;
        s_cfg.enable_mask <= 3'h7;
        d_mask[0] <= 3'h2;
        tick(8);
        note(1, 16'h0);
        note(8, 16'hB);
        // every detect mode on external line a, clear while high and low
        for (int m = 0; m < 4; m++) begin
            s_cfg.detect_mode[1] <= m[1:0];
            tick(8);
            clr();
            req_a <= 1'b1;
            tick(8);
            note(0, 16'h2);
            note(1, 16'(m != 2) << 1);
            note(3, 16'(m != 2));
            clr();
            tick(8);
            note(1, (m == 0) ? 16'h2 : 16'h0);
            req_a <= 1'b0;
            tick(8);
            note(1, (m == 3) ? 16'h0 : 16'h2);
        end
        req_a <= 1'b1;
        s_cfg.enable_mask <= 3'h5;
        tick(8);
        note(2, 16'h0);
        note(3, 16'h0);
        s_cfg.enable_mask <= 3'h7;
        d_mask[0] <= 3'h0;
        d_mask[1] <= 3'h2;
        tick(8);
        note(3, 16'h2);
        note(4, 16'h010);
        // bypass only on external line a; its latch stays set while pending follows the level
        s_cfg.latch_bypass[1] <= 1'b1;
        req_a <= 1'b0;
        tick(8);
        note(1, 16'h2);
        note(2, 16'h0);
        req_a <= 1'b1;
        s_cfg.latch_bypass[1] <= 1'b0;
        in_pol <= 2'h1;
        tick(8);
        note(0, 16'h6);
        in_pol <= 2'h3;
        // drive style and polarity settled before the pin is taken over
        for (int j = 0; j < 3; j++) begin
            sel <= 2'h0;
            d_mask[2] <= 3'h2;
            drv[0] <= (j == 2);
            out_pol[0] <= (j == 0);
            tick(2);
            sel <= 2'h1;
            tick(8);
            note(8, {12'h0, on_t[j]});
            note(0, 16'h0);
            d_mask[2] <= 3'h0;
            tick(8);
            note(8, {12'h0, off_t[j]});
        end
        // line b on its own: push-pull active high, line a left to its input
        sel <= 2'h2;
        d_mask[3] <= 3'h2;
        tick(8);
        note(9, 16'h5);
        note(8, 16'h3);
        d_mask[3] <= 3'h0;
        tick(8);
        note(9, 16'h0);
        sel <= 2'h0;
        m_cfg.enable_mask <= 8'hFF;
        tick(4);
        clr();
        e_lat = 8'h00;
        // random module levels and polarities, all in level mode
        for (int i = 0; i < 4; i++) begin
            r_irq = 8'($random(seed));
            r_pol = 8'($random(seed));
            r_en = (i == 3) ? 8'($random(seed)) : 8'hFF;
            m_irq <= r_irq;
            m_pol <= r_pol;
            m_cfg.enable_mask <= r_en;
            e_lat = e_lat | ~(r_irq ^ r_pol);
            tick(8);
            note(5, {8'h0, ~(r_irq ^ r_pol)});
            note(6, {8'h0, e_lat});
            note(7, {8'h0, e_lat & r_en});
            note(0, {15'h1, |(e_lat & r_en)});
        end
        tick(2);
        stop_test();
    end
endmodule : vectored_interrupt_router_tb
